// *** shared/status_groups_consts.vh ***
// Constants for the two-group status event filter block.
`ifndef STATUS_GROUPS_CONSTS_VH
`define STATUS_GROUPS_CONSTS_VH

// Register selectors on the host command port.
`define SEL_ACT_COND      4'h0
`define SEL_ACT_EVENT     4'h1
`define SEL_ACT_MASK      4'h2
`define SEL_ACT_RISE      4'h3
`define SEL_ACT_FALL      4'h4
`define SEL_FLT_COND      4'h8
`define SEL_FLT_EVENT     4'h9
`define SEL_FLT_MASK      4'ha
`define SEL_FLT_RISE      4'hb
`define SEL_FLT_FALL      4'hc

// Preset and reset values.
`define RISE_PRESET       16'h7fff
`define FALL_PRESET       16'h0000
`define MASK_PRESET       16'h0000

// Defined bits of each group.
`define ACT_DEFINED       16'h1f21
`define FLT_DEFINED       16'h573b

// Activity group bit positions.
`define ACT_CALIBRATING   0
`define ACT_AWAIT_TRIG    5
`define ACT_VOLT_REG      8
`define ACT_AUX_VOLT_REG  9
`define ACT_CURR_REG      10
`define ACT_NEG_CURR_REG  11
`define ACT_AUX_CURR_REG  12

// Fault group bit positions.
`define FLT_EXCESS_VOLT   0
`define FLT_EXCESS_CURR   1
`define FLT_LOCAL_KEY     3
`define FLT_OVERTEMP      4
`define FLT_SENSE_OPEN    5
`define FLT_AUX_UNREG     8
`define FLT_INHIBIT       9
`define FLT_OUT_UNREG     10
`define FLT_AUX_EXCESS_I  12
`define FLT_MEAS_OVERRNG  14

// Summary bit positions in the status byte.
`define SUM_FAULT_BIT     3
`define SUM_ACTIVITY_BIT  7

`endif

// *** rtl/status_group.v ***
// One status group: condition, transition filters, latched events, mask.
`timescale 1ns/100ps
`default_nettype none
`include "status_groups_consts.vh"

module status_group #(
    parameter        WIDTH   = 16,
    parameter [15:0] DEFINED = 16'hffff
) (
    input  wire             clock_i,       // System clock.
    input  wire             rst_n_i,       // Asynchronous reset, active low.
    input  wire             preset_i,      // Status preset pulse.
    input  wire [WIDTH-1:0] cond_i,        // Live condition bits.
    input  wire             wr_mask_i,     // Write strobe for the mask.
    input  wire             wr_rise_i,     // Write strobe for rising filter.
    input  wire             wr_fall_i,     // Write strobe for falling filter.
    input  wire [WIDTH-1:0] wdata_i,       // Write data.
    input  wire             rd_event_i,    // Clearing read of the event latch.
    output wire [WIDTH-1:0] cond_o,        // Masked live condition.
    output reg  [WIDTH-1:0] event_o,       // Latched event bits.
    output reg  [WIDTH-1:0] mask_o,        // Summary enable mask.
    output reg  [WIDTH-1:0] rise_o,        // Rising-edge filter.
    output reg  [WIDTH-1:0] fall_o,        // Falling-edge filter.
    output wire             summary_o      // OR of enabled events.
);
    reg  [WIDTH-1:0] cond_prev;
    wire [WIDTH-1:0] cond_live;
    wire [WIDTH-1:0] edge_hit;
    wire [WIDTH-1:0] next_event;

    assign cond_live = cond_i & DEFINED[WIDTH-1:0];
    assign cond_o    = cond_live;

    // Each bit passes rising and falling edges independently, so both or neither combine.
    assign edge_hit = (rise_o & cond_live & ~cond_prev)
                    | (fall_o & ~cond_live & cond_prev);

    // A new edge in the read cycle survives the clear.
    assign next_event = (rd_event_i ? {WIDTH{1'b0}} : event_o) | edge_hit;

    assign summary_o = |(event_o & mask_o);

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cond_prev <= {WIDTH{1'b0}};
            event_o   <= {WIDTH{1'b0}};
            mask_o    <= `MASK_PRESET;
            rise_o    <= `RISE_PRESET;
            fall_o    <= `FALL_PRESET;
        end else begin
            cond_prev <= cond_live;
            event_o   <= next_event & DEFINED[WIDTH-1:0];
            if (preset_i) begin
                mask_o <= `MASK_PRESET;
                rise_o <= `RISE_PRESET;
                fall_o <= `FALL_PRESET;
            end else begin
                if (wr_mask_i)
                    mask_o <= wdata_i;
                if (wr_rise_i)
                    rise_o <= wdata_i;
                if (wr_fall_i)
                    fall_o <= wdata_i;
            end
        end
    end
endmodule

`default_nettype wire

// *** rtl/status_event_filter_groups.v ***
// Two-group status event filter with summary bits and host register access.
`timescale 1ns/100ps
`default_nettype none
`include "status_groups_consts.vh"

// Function
// - A falling-edge filter bit of 1 latches the event when its condition goes 1 to 0.
// - A rising-edge filter bit of 1 latches the event when its condition goes 0 to 1.
// - With both filter bits set, either direction of change latches the event.
// - With both filter bits clear, that event bit is never set.
// - Preset loads the falling filter with 0 and the rising filter with 32767 per group.
// - The event register is read-only and holds each latched bit until read.
// - Reading a group's event register returns it and then clears it.
// - The condition register is read-only and shows live status.
// - Status byte bit 3 is the OR of fault events enabled by the fault mask.
// - Fault bits: volt trip 0, curr trip 1, key 3, heat 4, sense 5, aux curr 12, overrange 14.
// - Fault bits: output unregulated 10, inhibit 9, aux output unregulated 8.
// - Filter registers are writable and read back exactly as written.
// - Status byte bit 7 is the OR of activity events enabled by the activity mask.
// - Activity bits: cal 0, trig wait 5, volt 8, aux volt 9, curr 10, neg 11, aux curr 12.
// - Preset sets rising filters and clears falling filters and masks in both groups.
module status_event_filter_groups (
    input  wire        clock_i,                        // System clock, 125 MHz.
    input  wire        rst_n_i,                        // Asynchronous reset, active low.
    input  wire        calibrating_i,                  // Computing calibration constants.
    input  wire        awaiting_trigger_i,             // Waiting for a trigger.
    input  wire        voltage_regulating_i,           // Main output in voltage regulation.
    input  wire        aux_voltage_regulating_i,       // Aux output in voltage regulation.
    input  wire        current_regulating_i,           // Main output in current regulation.
    input  wire        negative_current_regulating_i,  // Negative current regulation.
    input  wire        aux_current_regulating_i,       // Aux output in current regulation.
    input  wire        excess_voltage_trip_i,          // Excess-voltage protection tripped.
    input  wire        excess_current_trip_i,          // Excess-current protection tripped.
    input  wire        local_key_pressed_i,            // Local key pressed.
    input  wire        overtemperature_trip_i,         // Overtemperature tripped.
    input  wire        sense_lead_open_i,              // Open sense lead.
    input  wire        aux_output_not_regulated_i,     // Aux output unregulated.
    input  wire        external_inhibit_active_i,      // External inhibit active.
    input  wire        output_not_regulated_i,         // Main output unregulated.
    input  wire        aux_excess_current_trip_i,      // Aux excess-current tripped.
    input  wire        meas_overrange_i,               // Measurement overrange.
    input  wire        preset_i,                       // Status preset pulse.
    input  wire        wr_i,                           // Register write strobe.
    input  wire        rd_i,                           // Register read strobe.
    input  wire [3:0]  sel_i,                          // Register selector.
    input  wire [15:0] wdata_i,                        // Write data.
    output reg  [15:0] rdata_o,                        // Read data, valid the cycle after rd_i.
    output reg         rvalid_o,                       // Read data valid pulse.
    output reg         activity_summary_o,             // Status byte bit 7.
    output reg         fault_summary_o,                // Status byte bit 3.
    output reg  [7:0]  status_byte_o                   // Summary bits at their byte positions.
);
    wire [15:0] act_cond_in;
    wire [15:0] flt_cond_in;
    wire [15:0] act_cond;
    wire [15:0] act_event;
    wire [15:0] act_mask;
    wire [15:0] act_rise;
    wire [15:0] act_fall;
    wire [15:0] flt_cond;
    wire [15:0] flt_event;
    wire [15:0] flt_mask;
    wire [15:0] flt_rise;
    wire [15:0] flt_fall;
    wire        act_sum;
    wire        flt_sum;
    reg  [15:0] next_rdata;
    reg  [7:0]  next_status;

    function hit;
        input [3:0] sel;
        input [3:0] code;
        begin
            hit = (sel == code);
        end
    endfunction

    assign act_cond_in = {3'h0, aux_current_regulating_i, negative_current_regulating_i,
                          current_regulating_i, aux_voltage_regulating_i,
                          voltage_regulating_i, 2'h0, awaiting_trigger_i, 4'h0,
                          calibrating_i};

    assign flt_cond_in = {1'b0, meas_overrange_i, 1'b0, aux_excess_current_trip_i, 1'b0,
                          output_not_regulated_i, external_inhibit_active_i,
                          aux_output_not_regulated_i, 2'h0, sense_lead_open_i,
                          overtemperature_trip_i, local_key_pressed_i, 1'b0,
                          excess_current_trip_i, excess_voltage_trip_i};

    status_group #(.WIDTH(16), .DEFINED(`ACT_DEFINED)) activity_group (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .preset_i   (preset_i),
        .cond_i     (act_cond_in),
        .wr_mask_i  (wr_i && hit(sel_i, `SEL_ACT_MASK)),
        .wr_rise_i  (wr_i && hit(sel_i, `SEL_ACT_RISE)),
        .wr_fall_i  (wr_i && hit(sel_i, `SEL_ACT_FALL)),
        .wdata_i    (wdata_i),
        .rd_event_i (rd_i && hit(sel_i, `SEL_ACT_EVENT)),
        .cond_o     (act_cond),
        .event_o    (act_event),
        .mask_o     (act_mask),
        .rise_o     (act_rise),
        .fall_o     (act_fall),
        .summary_o  (act_sum)
    );

    status_group #(.WIDTH(16), .DEFINED(`FLT_DEFINED)) fault_group (
        .clock_i    (clock_i),
        .rst_n_i    (rst_n_i),
        .preset_i   (preset_i),
        .cond_i     (flt_cond_in),
        .wr_mask_i  (wr_i && hit(sel_i, `SEL_FLT_MASK)),
        .wr_rise_i  (wr_i && hit(sel_i, `SEL_FLT_RISE)),
        .wr_fall_i  (wr_i && hit(sel_i, `SEL_FLT_FALL)),
        .wdata_i    (wdata_i),
        .rd_event_i (rd_i && hit(sel_i, `SEL_FLT_EVENT)),
        .cond_o     (flt_cond),
        .event_o    (flt_event),
        .mask_o     (flt_mask),
        .rise_o     (flt_rise),
        .fall_o     (flt_fall),
        .summary_o  (flt_sum)
    );

    // The event value is captured before the clear lands, so the read returns it whole.
    always @* begin
        case (sel_i)
            `SEL_ACT_COND:  next_rdata = act_cond;
            `SEL_ACT_EVENT: next_rdata = act_event;
            `SEL_ACT_MASK:  next_rdata = act_mask;
            `SEL_ACT_RISE:  next_rdata = act_rise;
            `SEL_ACT_FALL:  next_rdata = act_fall;
            `SEL_FLT_COND:  next_rdata = flt_cond;
            `SEL_FLT_EVENT: next_rdata = flt_event;
            `SEL_FLT_MASK:  next_rdata = flt_mask;
            `SEL_FLT_RISE:  next_rdata = flt_rise;
            `SEL_FLT_FALL:  next_rdata = flt_fall;
            default:        next_rdata = 16'h0000;
        endcase
    end

    always @* begin
        next_status = 8'h00;
        next_status[`SUM_FAULT_BIT]    = flt_sum;
        next_status[`SUM_ACTIVITY_BIT] = act_sum;
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o            <= 16'h0000;
            rvalid_o           <= 1'b0;
            activity_summary_o <= 1'b0;
            fault_summary_o    <= 1'b0;
            status_byte_o      <= 8'h00;
        end else begin
            rvalid_o           <= rd_i;
            if (rd_i)
                rdata_o <= next_rdata;
            activity_summary_o <= act_sum;
            fault_summary_o    <= flt_sum;
            status_byte_o      <= next_status;
        end
    end
endmodule

`default_nettype wire

// *** bench/status_event_filter_groups_chk.sv ***
// Concurrent checks on the ports of the status event filter block.
`timescale 1ns/100ps
`default_nettype none
`include "status_groups_consts.vh"
module status_event_filter_groups_chk (
    input wire logic        clock_i,            // Clock.
    input wire logic        rst_n_i,            // Reset, active low.
    input wire logic        preset_i,           // Preset.
    input wire logic        wr_i,               // Write strobe.
    input wire logic        rd_i,               // Read strobe.
    input wire logic [3:0]  sel_i,              // Selector.
    input wire logic [15:0] wdata_i,            // Write data.
    input wire logic [15:0] rdata_o,            // Read data.
    input wire logic        rvalid_o,           // Read valid.
    input wire logic        activity_summary_o, // Activity summary.
    input wire logic        fault_summary_o,    // Fault summary.
    input wire logic [7:0]  status_byte_o       // Status byte.
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    chk_read_answer: assert property (rd_i |=> rvalid_o)
        else $error("read not answered");
    chk_read_quiet: assert property (!rd_i |=> !rvalid_o)
        else $error("spurious read valid");
    chk_rdata_hold: assert property (!rd_i |=> $stable(rdata_o))
        else $error("read data moved without read");
    chk_byte_map: assert property (
        status_byte_o == {activity_summary_o, 3'h0, fault_summary_o, 3'h0})
        else $error("status byte layout wrong");
    chk_preset_sum: assert property (
        preset_i ##1 preset_i |=> !fault_summary_o && !activity_summary_o)
        else $error("summary set after preset");
    chk_unused_zero: assert property (rd_i && sel_i[2:1] == 2'h0 |=>
        (rdata_o & ~(($past(sel_i) > 4'h7) ? `FLT_DEFINED : `ACT_DEFINED)) == 16'h0)
        else $error("unused bit reads one");
    chk_preset_rise: assert property (preset_i && !wr_i ##1 rd_i && !wr_i && !preset_i
        && sel_i == `SEL_FLT_RISE |=> rdata_o == `RISE_PRESET)
        else $error("rising filter not preset");
    chk_write_back: assert property (wr_i && !preset_i ##1 rd_i && !wr_i && !preset_i
        && sel_i == $past(sel_i) && sel_i[2:0] >= 3'h2 && sel_i[2:0] <= 3'h4
        |=> rdata_o == $past(wdata_i, 2))
        else $error("register read back differs");
    chk_unmapped_zero: assert property (rd_i && sel_i[2:0] > 3'h4 |=> rdata_o == 16'h0)
        else $error("unmapped read not zero");
endmodule
`default_nettype wire

// *** bench/status_event_filter_groups_tb.sv ***
// Self-checking bench for the two-group status event filter.
`timescale 1ns/100ps
`default_nettype none
`include "status_groups_consts.vh"
module status_event_filter_groups_tb;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        preset_i = 1'b0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [3:0]  sel_i = 4'h0;
    logic [15:0] wdata_i = 16'h0;
    logic [15:0] act_c = 16'h0;
    logic [15:0] flt_c = 16'h0;
    logic [15:0] r;
    logic [15:0] exp_q[$];
    logic [3:0]  sels[6] = '{`SEL_FLT_RISE, `SEL_FLT_FALL, `SEL_FLT_MASK, `SEL_ACT_RISE,
                             `SEL_ACT_FALL, `SEL_ACT_MASK};
    logic [15:0] pre[6] = '{16'h7fff, 16'h0, 16'h0, 16'h7fff, 16'h0, 16'h0};
    wire  [15:0] rdata_o;
    wire         rvalid_o;
    wire         act_sum;
    wire         flt_sum;
    wire  [7:0]  status_byte_o;
    int          err_total = 0;
    int          check_count = 0;
    status_event_filter_groups i_dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .calibrating_i(act_c[0]),
        .awaiting_trigger_i(act_c[5]), .voltage_regulating_i(act_c[8]),
        .aux_voltage_regulating_i(act_c[9]), .current_regulating_i(act_c[10]),
        .negative_current_regulating_i(act_c[11]), .aux_current_regulating_i(act_c[12]),
        .excess_voltage_trip_i(flt_c[0]), .excess_current_trip_i(flt_c[1]),
        .local_key_pressed_i(flt_c[3]), .overtemperature_trip_i(flt_c[4]),
        .sense_lead_open_i(flt_c[5]), .aux_output_not_regulated_i(flt_c[8]),
        .external_inhibit_active_i(flt_c[9]), .output_not_regulated_i(flt_c[10]),
        .aux_excess_current_trip_i(flt_c[12]), .meas_overrange_i(flt_c[14]),
        .preset_i(preset_i), .wr_i(wr_i), .rd_i(rd_i), .sel_i(sel_i), .wdata_i(wdata_i),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o), .activity_summary_o(act_sum),
        .fault_summary_o(flt_sum), .status_byte_o(status_byte_o));
    initial begin
        forever #4 clock_i = ~clock_i;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        if (err_total == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // Strobes are left up so back-to-back accesses never assign twice in one step.
    task automatic acc(input logic w, input logic [3:0] s, input logic [15:0] d);
        wr_i <= w;
        rd_i <= !w;
        sel_i <= s;
        wdata_i <= d;
        if (!w) exp_q.push_back(d);
        @(posedge clock_i);
    endtask
    task automatic idle;
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge clock_i);
    endtask
    always @(posedge clock_i) begin
        if (rvalid_o === 1'b1) begin
            if (exp_q.size() == 0) check("read count", 16'h1, 16'h0);
            else check("read data", rdata_o, exp_q.pop_front());
        end
    end
    initial begin
        void'($urandom(32'h7fa9f8f0));
        cyc(10);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 6; i++) acc(1'b0, sels[i], pre[i]);
            for (int i = 0; i < 6; i++) begin
                r = 16'($urandom);
                acc(1'b1, sels[i], r);
                acc(1'b0, sels[i], r);
            end
            preset_i <= 1'b1;
            idle();
            idle();
            preset_i <= 1'b0;
        end
        acc(1'b1, `SEL_FLT_RISE, 16'h0009);
        acc(1'b1, `SEL_FLT_FALL, 16'h000a);
        acc(1'b1, `SEL_FLT_MASK, 16'h0008);
        acc(1'b1, `SEL_ACT_MASK, 16'h0100);
        idle();
        flt_c <= 16'h001b;
        act_c <= 16'h0100;
        cyc(4);
        check("fault summary", {15'h0, flt_sum}, 16'h1);
        check("activity summary", {15'h0, act_sum}, 16'h1);
        check("status byte", {8'h0, status_byte_o}, 16'h0088);
        acc(1'b0, `SEL_FLT_EVENT, 16'h0009);
        flt_c <= 16'h0000;
        acc(1'b0, `SEL_ACT_EVENT, 16'h0100);
        idle();
        cyc(3);
        acc(1'b0, `SEL_FLT_EVENT, 16'h000a);
        acc(1'b0, `SEL_FLT_EVENT, 16'h0000);
        idle();
        cyc(3);
        check("status byte", {8'h0, status_byte_o}, 16'h0000);
        flt_c <= 16'h0001;
        acc(1'b0, `SEL_FLT_EVENT, 16'h0000);
        acc(1'b0, `SEL_FLT_EVENT, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            r = 16'($urandom);
            act_c <= r;
            flt_c <= ~r;
            acc(1'b0, `SEL_ACT_COND, r & `ACT_DEFINED);
            acc(1'b0, `SEL_FLT_COND, ~r & `FLT_DEFINED);
        end
        acc(1'b1, `SEL_FLT_COND, 16'hffff);
        acc(1'b0, 4'hd, 16'h0000);
        acc(1'b0, `SEL_FLT_COND, ~r & `FLT_DEFINED);
        // Preset with events and masks live, so the summaries really have to drop.
        preset_i <= 1'b1;
        idle();
        idle();
        preset_i <= 1'b0;
        acc(1'b0, `SEL_FLT_MASK, 16'h0000);
        idle();
        for (int k = 0; k < 20 && exp_q.size() != 0; k++) cyc(1);
        check("pending reads", 16'(exp_q.size()), 16'h0);
        conclude();
    end
endmodule
bind status_event_filter_groups status_event_filter_groups_chk i_chk (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .preset_i(preset_i), .wr_i(wr_i), .rd_i(rd_i),
    .sel_i(sel_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .activity_summary_o(activity_summary_o), .fault_summary_o(fault_summary_o),
    .status_byte_o(status_byte_o));
`default_nettype wire
